// >>> mucyc_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - Counts assume no waits; waits stretch them.
// - Memory-source arithmetic and compare take three cycles.
// - Signed memory divide takes five to twenty-two.
// - Unsigned memory divide takes four to twenty.
// - Register wide multiply takes two cycles.
// - Memory wide multiply takes four cycles.
// - Byte accumulate: six, seven per four, four extra.
// - Word accumulate: six, five per pair, four extra.
// - Longword accumulate: six plus four per longword.
// - Accumulator saturation takes three cycles.
// - Memory moves take three cycles.
// - Bit operations on memory take three cycles.
// - Control register pop: throughput three, latency four.
// - Register range push takes one cycle each.
// - Register range pop: throughput n, latency n+1.
// - Swapping operands takes two cycles.
// - Return with release: thresholds five and four.
// - Range push issues one store per register.
// - Floor rounds down; percent is the remainder.
// - Latency applies only when next instruction consumes.
module mucyc_ctrl (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire mucyc_pkg::mucyc_op_type op_in,
  input wire logic [mucyc_pkg::CNT_W-1:0] count_in,
  input wire logic [mucyc_pkg::DIV_W-1:0] div_steps_in,
  input wire logic consumer_in,
  input wire logic mem_ready_in,
  output logic busy_out,
  output logic stall_out,
  output logic uop_valid_out,
  output logic uop_last_out,
  output logic [mucyc_pkg::CYC_W-1:0] uop_index_out,
  output logic done_out,
  output logic [mucyc_pkg::CYC_W-1:0] cycles_out
);
  localparam int CW = mucyc_pkg::CYC_W;

  mucyc_pkg::mucyc_state_type state;
  mucyc_pkg::mucyc_state_type next_state;
  logic [CW-1:0] elapsed;
  logic [CW-1:0] next_elapsed;
  logic [CW-1:0] thr;
  logic [CW-1:0] next_thr;
  logic [CW-1:0] eff;
  logic [CW-1:0] next_eff;
  logic next_busy;
  logic next_stall;
  logic next_uop_valid;
  logic next_uop_last;
  logic [CW-1:0] next_uop_index;
  logic next_done;
  logic accept;
  logic finish;

  mucyc_calc_if cif();

  assign cif.op = op_in;
  assign cif.count = count_in;
  assign cif.div_steps = div_steps_in;

  mucyc_calc u_calc (
    .cif(cif)
  );

  // Load-type instructions are those whose result reaches a register from memory.
  function automatic logic is_load(input mucyc_pkg::mucyc_op_type op);
    is_load = (op == mucyc_pkg::OP_POP_CONTROL_REGISTER) || (op == mucyc_pkg::OP_POP_REGISTER_RANGE)
      || (op == mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE);
  endfunction : is_load

  // A cycle only completes when memory answers; a wait state holds the cycle index.
  always_comb begin
    next_state = state;
    next_elapsed = elapsed;
    next_thr = thr;
    next_eff = eff;
    accept = 1'b0;
    finish = (state == mucyc_pkg::ST_RUN) && (elapsed == eff) && mem_ready_in;
    case (state)
      mucyc_pkg::ST_IDLE: begin
        accept = start_in;
      end
      mucyc_pkg::ST_RUN: begin
        if (finish) begin
          accept = start_in;
          next_state = mucyc_pkg::ST_IDLE;
        end else if (mem_ready_in) begin
          next_elapsed = elapsed + mucyc_pkg::MIN_CYC;
        end
      end
      default: begin
        next_state = mucyc_pkg::ST_IDLE;
      end
    endcase
    if (accept) begin
      next_state = mucyc_pkg::ST_RUN;
      next_elapsed = mucyc_pkg::MIN_CYC;
      next_thr = cif.thr;
      next_eff = (consumer_in && is_load(op_in)) ? cif.lat : cif.thr;
    end
    next_busy = (next_state == mucyc_pkg::ST_RUN);
    next_uop_valid = next_busy && (next_elapsed <= next_thr);
    next_stall = next_busy && (next_elapsed < next_thr);
    next_uop_last = next_busy && (next_elapsed == next_thr);
    next_uop_index = next_uop_valid ? next_elapsed - mucyc_pkg::MIN_CYC : '0;
    next_done = next_busy && (next_elapsed == next_eff);
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      state <= mucyc_pkg::ST_IDLE;
      elapsed <= '0;
      thr <= '0;
      eff <= '0;
      busy_out <= 1'b0;
      stall_out <= 1'b0;
      uop_valid_out <= 1'b0;
      uop_last_out <= 1'b0;
      uop_index_out <= '0;
      done_out <= 1'b0;
      cycles_out <= '0;
    end else begin
      state <= next_state;
      elapsed <= next_elapsed;
      thr <= next_thr;
      eff <= next_eff;
      busy_out <= next_busy;
      stall_out <= next_stall;
      uop_valid_out <= next_uop_valid;
      uop_last_out <= next_uop_last;
      uop_index_out <= next_uop_index;
      done_out <= next_done;
      cycles_out <= next_eff;
    end
  end

  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (rst_in);

  a_wait_holds_index: assert property (
    (busy_out && !mem_ready_in && !done_out) |=> $stable(uop_index_out) && $stable(elapsed))
    else $error("Cycle index moved during a wait state.");

  a_alu_mem_three: assert property (
    (cif.op == mucyc_pkg::OP_ALU_MEM) |-> (cif.thr == 20'h3))
    else $error("Memory-source arithmetic is not three cycles.");

  a_signed_divide_range: assert property (
    (cif.op == mucyc_pkg::OP_SIGNED_DIVIDE) |-> (cif.thr >= 20'h5) && (cif.thr <= 20'h16))
    else $error("Signed divide count out of range.");

  a_unsigned_divide_range: assert property (
    (cif.op == mucyc_pkg::OP_UNSIGNED_DIVIDE) |-> (cif.thr >= 20'h4) && (cif.thr <= 20'h14))
    else $error("Unsigned divide count out of range.");

  a_wide_mul_counts: assert property (
    ((cif.op == mucyc_pkg::OP_WIDE_MULTIPLY_REG) |-> (cif.thr == 20'h2))
    and ((cif.op == mucyc_pkg::OP_WIDE_MULTIPLY_MEM) |-> (cif.thr == 20'h4)))
    else $error("Wide multiply count wrong.");

  a_mac_byte_count: assert property (
    (cif.op == mucyc_pkg::OP_REPEAT_MAC_BYTE)
    |-> (int'(cif.thr) == 6 + 7 * (int'(cif.count) / 4) + 4 * (int'(cif.count) % 4)))
    else $error("Byte accumulate count wrong.");

  a_mac_word_count: assert property (
    (cif.op == mucyc_pkg::OP_REPEAT_MAC_WORD)
    |-> (int'(cif.thr) == 6 + 5 * (int'(cif.count) / 2) + 4 * (int'(cif.count) % 2)))
    else $error("Word accumulate count wrong.");

  a_mac_long_count: assert property (
    (cif.op == mucyc_pkg::OP_REPEAT_MAC_LONG) |-> (int'(cif.thr) == 6 + 4 * int'(cif.count)))
    else $error("Longword accumulate count wrong.");

  a_three_cycle_group: assert property (
    ((cif.op == mucyc_pkg::OP_ACCUMULATOR_SATURATE) || (cif.op == mucyc_pkg::OP_MOVE_MEM)
    || (cif.op == mucyc_pkg::OP_BIT_MEM)) |-> (cif.thr == 20'h3))
    else $error("Three-cycle instruction has another count.");

  a_ctrl_pop_timing: assert property (
    (cif.op == mucyc_pkg::OP_POP_CONTROL_REGISTER) |-> (cif.thr == 20'h3) && (cif.lat == 20'h4))
    else $error("Control register pop timing wrong.");

  a_range_push_pop: assert property (
    (((cif.op == mucyc_pkg::OP_PUSH_REGISTER_RANGE) && (cif.count != '0))
    |-> (int'(cif.thr) == int'(cif.count)))
    and (((cif.op == mucyc_pkg::OP_POP_REGISTER_RANGE) && (cif.count != '0))
    |-> (int'(cif.thr) == int'(cif.count)) && (int'(cif.lat) == int'(cif.count) + 1)))
    else $error("Register range count wrong.");

  a_return_release: assert property (
    (cif.op == mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE)
    |-> (int'(cif.thr) == ((cif.count < 5) ? 5 : 1 + int'(cif.count)))
    && (int'(cif.lat) == ((cif.count < 4) ? 5 : 2 + int'(cif.count))))
    else $error("Return with release timing wrong.");

  a_swap_two_cycles: assert property (
    (accept && (op_in == mucyc_pkg::OP_SWAP_OPERANDS)) ##1 mem_ready_in |=> done_out && uop_last_out)
    else $error("Swap did not finish in two cycles.");

  a_load_latency_used: assert property (
    (accept && consumer_in && is_load(op_in)) |=> (cycles_out == $past(cif.lat)))
    else $error("Consumed load does not use latency.");

  a_stall_until_last: assert property (
    $fell(stall_out) && busy_out |-> uop_last_out && uop_valid_out)
    else $error("Issue stall ended before the final micro-operation.");

  a_push_one_store_each: assert property (
    (uop_valid_out && !uop_last_out && mem_ready_in) |=> uop_valid_out
    && (uop_index_out == $past(uop_index_out) + 20'h1))
    else $error("Micro-operations not issued one per cycle.");

  a_last_not_stalled: assert property (
    uop_last_out
    |-> uop_valid_out && !stall_out)
    else $error("Final micro-operation still stalls issue.");

  a_stall_has_uop: assert property (
    stall_out
    |-> uop_valid_out && busy_out && !done_out)
    else $error("Issue stall without a micro-operation.");

  a_done_while_busy: assert property (
    done_out
    |-> busy_out)
    else $error("Instruction end flagged while idle.");

  a_idle_outputs_low: assert property (
    !busy_out
    |-> !stall_out && !uop_valid_out && !uop_last_out && !done_out && (uop_index_out == '0))
    else $error("Idle core shows activity.");

  a_first_uop_index: assert property (
    accept
    |=> busy_out && uop_valid_out && (uop_index_out == '0))
    else $error("First micro-operation not dispatched at index zero.");

  a_end_goes_idle: assert property (
    (done_out && mem_ready_in && !start_in)
    |=> !busy_out)
    else $error("Core still busy after the effective end.");

  a_restart_on_end: assert property (
    (done_out && mem_ready_in && start_in)
    |=> busy_out && uop_valid_out && (uop_index_out == '0))
    else $error("Back to back instruction did not restart.");

  a_first_cycle_stalls: assert property (
    (accept && (cif.thr != 20'h1))
    |=> stall_out)
    else $error("Issue not stalled by a multi-cycle instruction.");

  a_unused_load_thr: assert property (
    (accept && !(consumer_in && is_load(op_in)))
    |=> (cycles_out == $past(cif.thr)))
    else $error("Unconsumed instruction does not use throughput.");

  a_cycles_held: assert property (
    (busy_out && !(done_out && mem_ready_in))
    |=> $stable(cycles_out))
    else $error("Effective count changed while running.");

  a_index_in_range: assert property (
    uop_valid_out
    |-> (uop_index_out < thr))
    else $error("Micro-operation index beyond the throughput.");

  a_latency_no_uop: assert property (
    (done_out && !uop_last_out)
    |-> !uop_valid_out && !stall_out)
    else $error("Micro-operation dispatched in a latency cycle.");

  a_busy_no_restart: assert property (
    (busy_out && !done_out)
    |=> busy_out)
    else $error("Instruction ended before its count.");

  a_signed_divide_cap: assert property (
    (accept && (op_in == mucyc_pkg::OP_SIGNED_DIVIDE) && (div_steps_in == 5'h1f))
    |=> (cycles_out == 20'h16))
    else $error("Signed divide not capped at its maximum.");

  a_unsigned_divide_cap: assert property (
    (accept && (op_in == mucyc_pkg::OP_UNSIGNED_DIVIDE) && (div_steps_in == 5'h1f))
    |=> (cycles_out == 20'h14))
    else $error("Unsigned divide not capped at its maximum.");

  a_uop_count_thr: assert property (
    uop_last_out
    |-> (uop_index_out == thr - 20'h1))
    else $error("Final micro-operation index does not match the count.");

  a_range_pop_latency: assert property (
    (accept && consumer_in && (op_in == mucyc_pkg::OP_POP_REGISTER_RANGE) && (count_in == 16'h3))
    |=> (cycles_out == 20'h4))
    else $error("Consumed range pop of three does not take four cycles.");

  c_mac_byte: cover property (accept && (op_in == mucyc_pkg::OP_REPEAT_MAC_BYTE) && (count_in == 16'h7));
  c_pop_range_used: cover property (accept && (op_in == mucyc_pkg::OP_POP_REGISTER_RANGE) && consumer_in);
  c_wait_state: cover property (busy_out && !mem_ready_in ##1 busy_out && mem_ready_in);
  c_return_long: cover property (accept && (op_in == mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE)
    && (count_in == 16'h5));
  c_back_to_back: cover property (done_out && mem_ready_in && start_in);

endmodule : mucyc_ctrl

// >>> mucyc_pkg.sv
package mucyc_pkg;

  localparam int CNT_W = 16;
  localparam int DIV_W = 5;
  localparam int CYC_W = 20;

  typedef enum logic [3:0] {
    OP_ALU_MEM = 4'h0,
    OP_SIGNED_DIVIDE = 4'h1,
    OP_UNSIGNED_DIVIDE = 4'h2,
    OP_WIDE_MULTIPLY_REG = 4'h3,
    OP_WIDE_MULTIPLY_MEM = 4'h4,
    OP_REPEAT_MAC_BYTE = 4'h5,
    OP_REPEAT_MAC_WORD = 4'h6,
    OP_REPEAT_MAC_LONG = 4'h7,
    OP_ACCUMULATOR_SATURATE = 4'h8,
    OP_MOVE_MEM = 4'h9,
    OP_BIT_MEM = 4'ha,
    OP_POP_CONTROL_REGISTER = 4'hb,
    OP_PUSH_REGISTER_RANGE = 4'hc,
    OP_POP_REGISTER_RANGE = 4'hd,
    OP_SWAP_OPERANDS = 4'he,
    OP_RETURN_WITH_STACK_RELEASE = 4'hf
  } mucyc_op_type;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } mucyc_state_type;

  localparam logic [CYC_W-1:0] ALU_MEM_CYC = 20'h3;
  localparam logic [CYC_W-1:0] SDIV_MIN_CYC = 20'h5;
  localparam logic [CYC_W-1:0] SDIV_MAX_CYC = 20'h16;
  localparam logic [CYC_W-1:0] UDIV_MIN_CYC = 20'h4;
  localparam logic [CYC_W-1:0] UDIV_MAX_CYC = 20'h14;
  localparam logic [CYC_W-1:0] WMUL_REG_CYC = 20'h2;
  localparam logic [CYC_W-1:0] WMUL_MEM_CYC = 20'h4;
  localparam logic [CYC_W-1:0] REPEAT_MAC_BASE_CYC = 20'h6;
  localparam logic [CYC_W-1:0] REPEAT_MAC_BYTE_GRP_CYC = 20'h7;
  localparam logic [CYC_W-1:0] REPEAT_MAC_BYTE_ODD_CYC = 20'h4;
  localparam logic [CYC_W-1:0] REPEAT_MAC_WORD_GRP_CYC = 20'h5;
  localparam logic [CYC_W-1:0] REPEAT_MAC_WORD_ODD_CYC = 20'h4;
  localparam logic [CYC_W-1:0] REPEAT_MAC_LONG_CYC = 20'h4;
  localparam logic [CYC_W-1:0] SATURATE_CYC = 20'h3;
  localparam logic [CYC_W-1:0] MOVE_MEM_CYC = 20'h3;
  localparam logic [CYC_W-1:0] BIT_MEM_CYC = 20'h3;
  localparam logic [CYC_W-1:0] CTRL_POP_THR_CYC = 20'h3;
  localparam logic [CYC_W-1:0] CTRL_POP_LAT_CYC = 20'h4;
  localparam logic [CYC_W-1:0] RANGE_POP_LAT_ADD = 20'h1;
  localparam logic [CYC_W-1:0] SWAP_CYC = 20'h2;
  localparam logic [CYC_W-1:0] RETURN_MIN_CYC = 20'h5;
  localparam logic [CYC_W-1:0] RETURN_THR_LIMIT = 20'h5;
  localparam logic [CYC_W-1:0] RETURN_LAT_LIMIT = 20'h4;
  localparam logic [CYC_W-1:0] RETURN_THR_ADD = 20'h1;
  localparam logic [CYC_W-1:0] RETURN_LAT_ADD = 20'h2;
  localparam logic [CYC_W-1:0] MIN_CYC = 20'h1;

endpackage : mucyc_pkg

// >>> mucyc_calc_if.sv
`timescale 1ns/100ps
interface mucyc_calc_if;
  mucyc_pkg::mucyc_op_type op;
  logic [mucyc_pkg::CNT_W-1:0] count;
  logic [mucyc_pkg::DIV_W-1:0] div_steps;
  logic [mucyc_pkg::CYC_W-1:0] thr;
  logic [mucyc_pkg::CYC_W-1:0] lat;

  modport calc (input op, input count, input div_steps, output thr, output lat);
  modport user (output op, output count, output div_steps, input thr, input lat);
endinterface : mucyc_calc_if

// >>> mucyc_calc.sv
`timescale 1ns/100ps
module mucyc_calc (
  mucyc_calc_if.calc cif
);
  localparam int CW = mucyc_pkg::CYC_W;

  logic [CW-1:0] n_ext;
  logic [CW-1:0] d_ext;
  logic [CW-1:0] sdiv;
  logic [CW-1:0] udiv;

  // Floor of n over a power of two is a shift, the remainder is the low bits.
  always_comb begin
    n_ext = CW'(cif.count);
    d_ext = CW'(cif.div_steps);
    sdiv = mucyc_pkg::SDIV_MIN_CYC + d_ext;
    udiv = mucyc_pkg::UDIV_MIN_CYC + d_ext;
    cif.thr = mucyc_pkg::MIN_CYC;
    cif.lat = mucyc_pkg::MIN_CYC;
    case (cif.op)
      mucyc_pkg::OP_ALU_MEM: begin
        cif.thr = mucyc_pkg::ALU_MEM_CYC;
      end
      mucyc_pkg::OP_SIGNED_DIVIDE: begin
        cif.thr = (sdiv > mucyc_pkg::SDIV_MAX_CYC) ? mucyc_pkg::SDIV_MAX_CYC : sdiv;
      end
      mucyc_pkg::OP_UNSIGNED_DIVIDE: begin
        cif.thr = (udiv > mucyc_pkg::UDIV_MAX_CYC) ? mucyc_pkg::UDIV_MAX_CYC : udiv;
      end
      mucyc_pkg::OP_WIDE_MULTIPLY_REG: begin
        cif.thr = mucyc_pkg::WMUL_REG_CYC;
      end
      mucyc_pkg::OP_WIDE_MULTIPLY_MEM: begin
        cif.thr = mucyc_pkg::WMUL_MEM_CYC;
      end
      mucyc_pkg::OP_REPEAT_MAC_BYTE: begin
        cif.thr = CW'(mucyc_pkg::REPEAT_MAC_BASE_CYC + mucyc_pkg::REPEAT_MAC_BYTE_GRP_CYC * (n_ext >> 2)
          + mucyc_pkg::REPEAT_MAC_BYTE_ODD_CYC * CW'(n_ext[1:0]));
      end
      mucyc_pkg::OP_REPEAT_MAC_WORD: begin
        cif.thr = CW'(mucyc_pkg::REPEAT_MAC_BASE_CYC + mucyc_pkg::REPEAT_MAC_WORD_GRP_CYC * (n_ext >> 1)
          + mucyc_pkg::REPEAT_MAC_WORD_ODD_CYC * CW'(n_ext[0]));
      end
      mucyc_pkg::OP_REPEAT_MAC_LONG: begin
        cif.thr = CW'(mucyc_pkg::REPEAT_MAC_BASE_CYC + mucyc_pkg::REPEAT_MAC_LONG_CYC * n_ext);
      end
      mucyc_pkg::OP_ACCUMULATOR_SATURATE: begin
        cif.thr = mucyc_pkg::SATURATE_CYC;
      end
      mucyc_pkg::OP_MOVE_MEM: begin
        cif.thr = mucyc_pkg::MOVE_MEM_CYC;
      end
      mucyc_pkg::OP_BIT_MEM: begin
        cif.thr = mucyc_pkg::BIT_MEM_CYC;
      end
      mucyc_pkg::OP_POP_CONTROL_REGISTER: begin
        cif.thr = mucyc_pkg::CTRL_POP_THR_CYC;
        cif.lat = mucyc_pkg::CTRL_POP_LAT_CYC;
      end
      mucyc_pkg::OP_PUSH_REGISTER_RANGE: begin
        cif.thr = (n_ext == '0) ? mucyc_pkg::MIN_CYC : n_ext;
      end
      mucyc_pkg::OP_POP_REGISTER_RANGE: begin
        cif.thr = (n_ext == '0) ? mucyc_pkg::MIN_CYC : n_ext;
        cif.lat = cif.thr + mucyc_pkg::RANGE_POP_LAT_ADD;
      end
      mucyc_pkg::OP_SWAP_OPERANDS: begin
        cif.thr = mucyc_pkg::SWAP_CYC;
      end
      mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE: begin
        cif.thr = (n_ext < mucyc_pkg::RETURN_THR_LIMIT) ? mucyc_pkg::RETURN_MIN_CYC
          : n_ext + mucyc_pkg::RETURN_THR_ADD;
        cif.lat = (n_ext < mucyc_pkg::RETURN_LAT_LIMIT) ? mucyc_pkg::RETURN_MIN_CYC
          : n_ext + mucyc_pkg::RETURN_LAT_ADD;
      end
      default: begin
        cif.thr = mucyc_pkg::MIN_CYC;
      end
    endcase
    if (cif.lat < cif.thr) begin
      cif.lat = cif.thr;
    end
  end

endmodule : mucyc_calc

// >>> mucyc_mem_model.sv
`timescale 1ns/100ps
module mucyc_mem_model (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic busy_in,
  input wire logic [3:0] waits_in,
  output logic mem_ready_out
);
  logic [3:0] left;
  logic [3:0] next_left;
  always_comb begin
    next_left = left;
    if (!busy_in) begin
      next_left = waits_in;
    end else if (left != 4'h0) begin
      next_left = left - 4'h1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      left <= 4'h0;
    end else begin
      left <= next_left;
    end
  end
  // Holds each requested wait state at the start of an instruction begun from idle.
  assign mem_ready_out = !(busy_in && left != 4'h0);
endmodule : mucyc_mem_model

// >>> tb_top.sv
`timescale 1ns/100ps
module tb_top;
  typedef struct {mucyc_pkg::mucyc_op_type op; int n; int d; bit cons;} mucyc_case_type;
  logic clk_sys_in, rst_in, start_in, consumer_in, mem_ready_in;
  mucyc_pkg::mucyc_op_type op_in;
  logic [15:0] count_in;
  logic [4:0] div_steps_in;
  logic [3:0] waits_in;
  logic busy_out, stall_out, uop_valid_out, uop_last_out, done_out;
  logic [19:0] uop_index_out, cycles_out;
  int bad_count = 0;
  int num_checks = 0;
  mucyc_ctrl i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .start_in(start_in), .op_in(op_in),
    .count_in(count_in), .div_steps_in(div_steps_in), .consumer_in(consumer_in),
    .mem_ready_in(mem_ready_in), .busy_out(busy_out), .stall_out(stall_out),
    .uop_valid_out(uop_valid_out), .uop_last_out(uop_last_out), .uop_index_out(uop_index_out),
    .done_out(done_out), .cycles_out(cycles_out));
  mucyc_mem_model i_mem (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .busy_in(busy_out),
    .waits_in(waits_in), .mem_ready_out(mem_ready_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok) begin
      bad_count++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask : check
  function automatic int exp_thr(input mucyc_case_type c);
    case (c.op)
      mucyc_pkg::OP_SIGNED_DIVIDE: return (5 + c.d > 22) ? 22 : 5 + c.d;
      mucyc_pkg::OP_UNSIGNED_DIVIDE: return (4 + c.d > 20) ? 20 : 4 + c.d;
      mucyc_pkg::OP_WIDE_MULTIPLY_REG, mucyc_pkg::OP_SWAP_OPERANDS: return 2;
      mucyc_pkg::OP_WIDE_MULTIPLY_MEM: return 4;
      mucyc_pkg::OP_REPEAT_MAC_BYTE: return 6 + 7 * (c.n / 4) + 4 * (c.n % 4);
      mucyc_pkg::OP_REPEAT_MAC_WORD: return 6 + 5 * (c.n / 2) + 4 * (c.n % 2);
      mucyc_pkg::OP_REPEAT_MAC_LONG: return 6 + 4 * c.n;
      mucyc_pkg::OP_PUSH_REGISTER_RANGE, mucyc_pkg::OP_POP_REGISTER_RANGE: return (c.n == 0) ? 1 : c.n;
      mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE: return (c.n < 5) ? 5 : 1 + c.n;
      default: return 3;
    endcase
  endfunction : exp_thr
  function automatic int exp_lat(input mucyc_case_type c, input int thr);
    if (!c.cons) return thr;
    case (c.op)
      mucyc_pkg::OP_POP_CONTROL_REGISTER: return 4;
      mucyc_pkg::OP_POP_REGISTER_RANGE: return c.n + 1;
      mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE: return (c.n < 4) ? 5 : 2 + c.n;
      default: return thr;
    endcase
  endfunction : exp_lat
  task automatic run_op(input mucyc_case_type c, input int waits);
    int thr, lat, cyc, last_at, stalls, uops, done_at;
    thr = exp_thr(c);
    lat = exp_lat(c, thr);
    waits_in = waits[3:0];
    start_in = 1'b1;
    op_in = c.op;
    count_in = c.n[15:0];
    div_steps_in = c.d[4:0];
    consumer_in = c.cons;
    @(posedge clk_sys_in);
    #1;
    start_in = 1'b0;
    cyc = 1;
    last_at = 0;
    stalls = 0;
    uops = 0;
    done_at = 0;
    while (done_at == 0 && cyc < 100) begin
      if (cyc == 1) check(cycles_out === 20'(lat), "effective cycle count wrong");
      if (stall_out === 1'b1) stalls++;
      if (uop_valid_out === 1'b1) uops++;
      if (uop_valid_out === 1'b1 && waits == 0) check(uop_index_out === 20'(cyc - 1), "index wrong");
      if (uop_last_out === 1'b1) last_at = cyc;
      if (done_out === 1'b1 && mem_ready_in === 1'b1) begin
        done_at = cyc;
      end else begin
        @(posedge clk_sys_in);
        #1;
        cyc++;
      end
    end
    check(done_at == lat + waits, "completion cycle wrong");
    if (waits == 0) begin
      check(last_at == thr, "final micro-op cycle wrong");
      check(stalls == thr - 1, "issue stall length wrong");
      check(uops == thr, "micro-op dispatch count wrong");
    end
    waits_in = 4'h0;
    @(posedge clk_sys_in);
    #1;
    check(busy_out === 1'b0 && stall_out === 1'b0, "not idle after end");
    $display("test %s n=%0d ended after %0d cycles", c.op.name(), c.n, done_at);
  endtask : run_op
  task automatic back_to_back;
    logic [4:0] dv, bv, sv;
    start_in = 1'b1;
    op_in = mucyc_pkg::OP_SWAP_OPERANDS;
    count_in = 16'h0000;
    consumer_in = 1'b0;
    @(posedge clk_sys_in);
    #1;
    for (int cyc = 0; cyc < 5; cyc++) begin
      if (cyc == 2) start_in = 1'b0;
      dv[cyc] = done_out;
      bv[cyc] = busy_out;
      sv[cyc] = stall_out;
      @(posedge clk_sys_in);
      #1;
    end
    check(dv === 5'h0a && bv === 5'h0f, "back to back swap timing wrong");
    check(sv === 5'h05, "back to back stall pattern wrong");
    $display("test back to back swap ended");
  endtask : back_to_back
  initial begin
    rst_in = 1'b1;
    start_in = 1'b0;
    op_in = mucyc_pkg::OP_ALU_MEM;
    count_in = 16'h0000;
    div_steps_in = 5'h00;
    consumer_in = 1'b0;
    waits_in = 4'h0;
    repeat (20) @(posedge clk_sys_in);
    #1;
    rst_in = 1'b0;
    run_op('{mucyc_pkg::OP_ALU_MEM, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_ALU_MEM, 0, 0, 0}, 2);
    run_op('{mucyc_pkg::OP_SIGNED_DIVIDE, 0, 3, 0}, 0);
    run_op('{mucyc_pkg::OP_SIGNED_DIVIDE, 0, 31, 0}, 0);
    run_op('{mucyc_pkg::OP_UNSIGNED_DIVIDE, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_UNSIGNED_DIVIDE, 0, 31, 0}, 0);
    run_op('{mucyc_pkg::OP_WIDE_MULTIPLY_REG, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_WIDE_MULTIPLY_MEM, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_REPEAT_MAC_BYTE, 7, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_REPEAT_MAC_BYTE, 4, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_REPEAT_MAC_WORD, 3, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_REPEAT_MAC_LONG, 3, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_ACCUMULATOR_SATURATE, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_MOVE_MEM, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_BIT_MEM, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_POP_CONTROL_REGISTER, 0, 0, 1}, 0);
    run_op('{mucyc_pkg::OP_POP_CONTROL_REGISTER, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_PUSH_REGISTER_RANGE, 5, 0, 1}, 0);
    run_op('{mucyc_pkg::OP_POP_REGISTER_RANGE, 3, 0, 1}, 0);
    run_op('{mucyc_pkg::OP_POP_REGISTER_RANGE, 3, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_SWAP_OPERANDS, 0, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE, 3, 0, 1}, 0);
    run_op('{mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE, 4, 0, 1}, 0);
    run_op('{mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE, 5, 0, 0}, 0);
    run_op('{mucyc_pkg::OP_RETURN_WITH_STACK_RELEASE, 0, 0, 0}, 0);
    back_to_back();
    report_and_stop();
  end
  initial begin
    #100000;
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : tb_top
